// ==== logic/pec_counters.sv ====
// Operation
// (RL1) Two counters, two controls at register 25
// (RL2) Select 0..3: ctl0, cnt0, ctl1, cnt1
// (RL3) 32-bit read/write count, plus one per event
// (RL4) Counters independent, one event each
// (RL5) Interrupt is OR of bit31 AND enable
// (RL6) Interrupt never stalls counting
// (RL7) Interrupt clears on wrap or bit31 write
// (RL8) No counting while core clock stopped
// (RL9) Control bit31 read-only preset, more pairs
// (RL10) Bits 10:5 read/write event number
// (RL11) Bits 14:11 read/write extended selector
// (RL12) Bit 4 interrupt enable, resets zero
// (RL13) Bit 3 counts in user mode
// (RL14) Bit 1 kernel mode, both flags zero
// (RL15) Bit 0 counts at exception level
// (RL16) Bits 30:15 and 2 read zero
// (RL17) Mode enables gate only mode-sensitive events
// (RL18) Software avoids reserved event numbers
// (RL19) No counting in debug or error level
// (RL20) Idle after reset until control written
// (RL21) Counter 0 event code table
// (RL22) Counter 1 event code table
// (RL23) Wrap to zero, count writes immediate
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pec_counters #(
  parameter logic MORE_PAIRS   = 1'b0,
  parameter logic VIRT_PRESENT = 1'b0
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Core side
  pec_if.device           link,
  // Status
  output logic      [1:0] counting
);

  // Counter 0 reports a further pair at selects 2 and 3
  function automatic logic more_bit(input logic unit);
    more_bit = unit ? MORE_PAIRS : 1'b1; // RL9
  endfunction

  // Event codes that have a source for each counter
  function automatic logic implemented(input logic unit,
                                       input logic [5:0] code);
    implemented = 1'b0;
    if (code == pec_pkg::EV_CYCLES || code == pec_pkg::EV_INSTR) begin
      implemented = 1'b1;
    end else if (!unit) begin
      case (code) // RL21
        pec_pkg::EV0_BRANCH, pec_pkg::EV0_RETURN,
        pec_pkg::EV0_REGJUMP, pec_pkg::EV0_INTEGER,
        pec_pkg::EV0_LOAD, pec_pkg::EV0_DIRJUMP,
        pec_pkg::EV0_NOP, pec_pkg::EV0_STALL,
        pec_pkg::EV0_CSTORE, pec_pkg::EV0_PREFETCH,
        pec_pkg::EV0_EXCEPT, pec_pkg::EV0_CUSTOM: implemented = 1'b1;
        default: implemented = 1'b0;
      endcase
    end else begin
      case (code) // RL22
        pec_pkg::EV1_STORE, pec_pkg::EV1_COMPACT,
        pec_pkg::EV1_MULDIV, pec_pkg::EV1_CSFAIL,
        pec_pkg::EV1_ALUSTALL, pec_pkg::EV1_COP2EVT,
        pec_pkg::EV1_COP2MOVE: implemented = 1'b1;
        default: implemented = 1'b0;
      endcase
    end
  endfunction

  // Cycle and stall events ignore the mode enables
  function automatic logic mode_sensitive(input logic unit,
                                          input logic [5:0] code);
    mode_sensitive = 1'b1;
    if (code == pec_pkg::EV_CYCLES) begin
      mode_sensitive = 1'b0; // RL17
    end else if (!unit && code == pec_pkg::EV0_STALL) begin
      mode_sensitive = 1'b0; // RL17
    end else if (unit && code == pec_pkg::EV1_ALUSTALL) begin
      mode_sensitive = 1'b0; // RL17
    end
  endfunction

  logic [3:0]  ext       [2];
  logic [5:0]  evt       [2];
  logic        irq_en    [2];
  logic        cnt_user  [2];
  logic        cnt_kern  [2];
  logic        cnt_exc   [2];
  logic        armed     [2];
  logic [31:0] cnt       [2];
  logic [1:0]  ctl_wr;
  logic [1:0]  cnt_wr;
  logic [1:0]  inc;
  logic        hit;
  logic [31:0] next_rdata;

  function automatic logic [31:0] ctl_word(input logic unit);
    logic [31:0] w;
    w = pec_pkg::ZERO_WORD; // RL16
    w[pec_pkg::MORE_BIT] = more_bit(unit); // RL9
    if (VIRT_PRESENT) begin
      w[pec_pkg::EXT_HI:pec_pkg::EXT_LO] = ext[unit]; // RL11
    end
    w[pec_pkg::EVT_HI:pec_pkg::EVT_LO] = evt[unit]; // RL10
    w[pec_pkg::IRQ_BIT]  = irq_en[unit];
    w[pec_pkg::USER_BIT] = cnt_user[unit];
    w[pec_pkg::KERN_BIT] = cnt_kern[unit];
    w[pec_pkg::EXC_BIT]  = cnt_exc[unit];
    ctl_word = w;
  endfunction

  // Access decode
  assign hit = link.reg_num == pec_pkg::REG_NUM; // RL1

  always_comb begin
    ctl_wr = 2'h0;
    cnt_wr = 2'h0;
    if (link.move_to_sysctl && hit) begin
      if (link.sel == pec_pkg::SEL_CTL0) begin // RL2
        ctl_wr[0] = 1'b1;
      end else if (link.sel == pec_pkg::SEL_CNT0) begin
        cnt_wr[0] = 1'b1;
      end else if (link.sel == pec_pkg::SEL_CTL1) begin
        ctl_wr[1] = 1'b1;
      end else if (link.sel == pec_pkg::SEL_CNT1) begin
        cnt_wr[1] = 1'b1;
      end
    end
  end

  // Count qualification per counter
  always_comb begin
    logic mode_ok;
    logic allow;
    logic [5:0] code;
    logic ev_hit;
    mode_ok = 1'b0;
    allow   = 1'b0;
    code    = 6'h00;
    ev_hit  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      code    = evt[i];
      ev_hit  = (i == 0) ? link.ev0[code] : link.ev1[code]; // RL4
      mode_ok = (cnt_user[i] && link.user_mode && // RL13
                 !link.exception_level_flag)
             || (cnt_kern[i] && !link.user_mode && // RL14
                 !link.exception_level_flag && !link.error_level_flag)
             || (cnt_exc[i] && link.exception_level_flag && // RL15
                 !link.error_level_flag);
      allow = link.clk_run // RL8
           && armed[i] // RL20
           && !link.debug_mode && !link.error_level_flag // RL19
           && implemented(i[0], code)
           && (!mode_sensitive(i[0], code) || mode_ok); // RL17
      inc[i]      = allow && ev_hit;
      counting[i] = allow;
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        ext[i]      <= 4'h0;
        evt[i]      <= 6'h00;
        irq_en[i]   <= 1'b0; // RL12
        cnt_user[i] <= 1'b0;
        cnt_kern[i] <= 1'b0;
        cnt_exc[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctl_wr[i]) begin
          ext[i]      <= link.wdata[pec_pkg::EXT_HI:pec_pkg::EXT_LO]; // RL11
          evt[i]      <= link.wdata[pec_pkg::EVT_HI:pec_pkg::EVT_LO]; // RL10
          irq_en[i]   <= link.wdata[pec_pkg::IRQ_BIT]; // RL12
          cnt_user[i] <= link.wdata[pec_pkg::USER_BIT]; // RL13
          cnt_kern[i] <= link.wdata[pec_pkg::KERN_BIT]; // RL14
          cnt_exc[i]  <= link.wdata[pec_pkg::EXC_BIT]; // RL15
        end
      end
    end
  end

  // Low-power hold until the first control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed[0] <= 1'b0;
      armed[1] <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctl_wr[i]) begin
          armed[i] <= 1'b1; // RL20
        end
      end
    end
  end

  // Counters; a software write wins over an increment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt[0] <= pec_pkg::ZERO_WORD;
      cnt[1] <= pec_pkg::ZERO_WORD;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cnt_wr[i]) begin
          cnt[i] <= link.wdata; // RL23
        end else if (inc[i]) begin
          cnt[i] <= cnt[i] + pec_pkg::ONE_WORD; // RL3 RL23
        end
      end
    end
  end

  // Interrupt taken straight from count and enable
  assign link.counter_irq =
      (cnt[0][pec_pkg::CNT_MSB] && irq_en[0]) || // RL5 RL6 RL7
      (cnt[1][pec_pkg::CNT_MSB] && irq_en[1]);   // RL5 RL7

  // Read data, one cycle after the read strobe
  always_comb begin
    next_rdata = pec_pkg::ZERO_WORD;
    if (link.sel == pec_pkg::SEL_CTL0) begin // RL2
      next_rdata = ctl_word(1'b0);
    end else if (link.sel == pec_pkg::SEL_CNT0) begin
      next_rdata = cnt[0]; // RL3
    end else if (link.sel == pec_pkg::SEL_CTL1) begin
      next_rdata = ctl_word(1'b1);
    end else if (link.sel == pec_pkg::SEL_CNT1) begin
      next_rdata = cnt[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.rdata <= pec_pkg::ZERO_WORD;
    end else if (link.move_from_sysctl) begin
      link.rdata <= hit ? next_rdata : pec_pkg::ZERO_WORD; // RL1
    end
  end

endmodule
`default_nettype wire

// ==== logic/pec_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pec_host (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  // Pipeline events
  input  wire logic [63:0] ev0_in,
  input  wire logic [63:0] ev1_in,
  output logic             irq_out,
  // Counter unit
  pec_if.host              link
);

  typedef enum logic [2:0] {
    PEC_IDLE    = 3'b001,
    PEC_ISSUE   = 3'b010,
    PEC_CAPTURE = 3'b100
  } pec_state_t;

  pec_state_t  state;
  logic [31:0] data_reg;
  logic [31:0] cmd_reg;
  logic [31:0] result;
  logic [4:0]  mode;
  logic        wr_pend;
  logic [7:0]  addr_q;
  logic        start;

  assign hreadyout = 1'b1;
  assign hresp     = pec_pkg::HRESP_OKAY;
  assign irq_out   = link.counter_irq;
  assign start     = wr_pend && addr_q == pec_pkg::H_CMD
                  && state == PEC_IDLE;

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q  <= 8'h00;
      hrdata  <= pec_pkg::ZERO_WORD;
    end else begin
      wr_pend <= 1'b0;
      if (hsel && hready && htrans == pec_pkg::HTRANS_NSEQ) begin
        addr_q  <= haddr[7:0];
        wr_pend <= hwrite;
        if (!hwrite) begin
          if (haddr[7:0] == pec_pkg::H_DATA) begin
            hrdata <= data_reg;
          end else if (haddr[7:0] == pec_pkg::H_CMD) begin
            hrdata <= cmd_reg;
          end else if (haddr[7:0] == pec_pkg::H_RESULT) begin
            hrdata <= result;
          end else if (haddr[7:0] == pec_pkg::H_MODE) begin
            hrdata <= {27'h0, mode};
          end else if (haddr[7:0] == pec_pkg::H_STATUS) begin
            hrdata <= {30'h0, state != PEC_IDLE, link.counter_irq};
          end else begin
            hrdata <= pec_pkg::ZERO_WORD;
          end
        end
      end
    end
  end

  // Data phase writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= pec_pkg::ZERO_WORD;
      cmd_reg  <= pec_pkg::ZERO_WORD;
      mode     <= 5'h00;
    end else if (wr_pend) begin
      if (addr_q == pec_pkg::H_DATA) begin
        data_reg <= hwdata;
      end else if (addr_q == pec_pkg::H_CMD && state == PEC_IDLE) begin
        cmd_reg <= hwdata;
      end else if (addr_q == pec_pkg::H_MODE) begin
        mode <= hwdata[4:0];
      end
    end
  end

  // Register move sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PEC_IDLE;
    end else begin
      case (state)
        PEC_IDLE: begin
          if (start) begin
            state <= PEC_ISSUE;
          end
        end
        PEC_ISSUE: begin
          state <= cmd_reg[pec_pkg::CMD_WR_BIT] ? PEC_IDLE : PEC_CAPTURE;
        end
        PEC_CAPTURE: begin
          state <= PEC_IDLE;
        end
        default: begin
          state <= PEC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= pec_pkg::ZERO_WORD;
    end else if (state == PEC_CAPTURE) begin
      result <= link.rdata;
    end
  end

  // Events toward the counter unit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.ev0 <= 64'h0;
      link.ev1 <= 64'h0;
    end else begin
      link.ev0 <= ev0_in;
      link.ev1 <= ev1_in;
    end
  end

  assign link.reg_num = cmd_reg[pec_pkg::CMD_NUM_LO +: 5];
  assign link.sel     = cmd_reg[pec_pkg::CMD_SEL_LO +: 3];
  assign link.wdata   = data_reg;
  assign link.move_to_sysctl   = state == PEC_ISSUE
                              && cmd_reg[pec_pkg::CMD_WR_BIT];
  assign link.move_from_sysctl = state == PEC_ISSUE
                              && !cmd_reg[pec_pkg::CMD_WR_BIT];
  assign link.user_mode            = mode[pec_pkg::MODE_USER];
  assign link.exception_level_flag = mode[pec_pkg::MODE_EXC];
  assign link.error_level_flag     = mode[pec_pkg::MODE_ERR];
  assign link.debug_mode           = mode[pec_pkg::MODE_DEBUG];
  assign link.clk_run              = !mode[pec_pkg::MODE_SLEEP];

endmodule
`default_nettype wire

// ==== shared/pec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pec_if;
  // Register moves
  logic [4:0]  reg_num;
  logic [2:0]  sel;
  logic        move_to_sysctl;
  logic        move_from_sysctl;
  logic [31:0] wdata;
  logic [31:0] rdata;
  // Pipeline events and mode
  logic [63:0] ev0;
  logic [63:0] ev1;
  logic        user_mode;
  logic        exception_level_flag;
  logic        error_level_flag;
  logic        debug_mode;
  logic        clk_run;
  // Interrupt
  logic        counter_irq;

  modport device (
    input  reg_num, sel, move_to_sysctl, move_from_sysctl, wdata,
    input  ev0, ev1, user_mode, exception_level_flag,
    input  error_level_flag, debug_mode, clk_run,
    output rdata, counter_irq
  );
  modport host (
    output reg_num, sel, move_to_sysctl, move_from_sysctl, wdata,
    output ev0, ev1, user_mode, exception_level_flag,
    output error_level_flag, debug_mode, clk_run,
    input  rdata, counter_irq
  );
endinterface
`default_nettype wire

// ==== shared/pec_pkg.sv ====
package pec_pkg;
  // Register move addressing
  localparam logic [4:0]  REG_NUM      = 5'h19;
  localparam logic [2:0]  SEL_CTL0     = 3'h0;
  localparam logic [2:0]  SEL_CNT0     = 3'h1;
  localparam logic [2:0]  SEL_CTL1     = 3'h2;
  localparam logic [2:0]  SEL_CNT1     = 3'h3;
  // Control word fields
  localparam int          MORE_BIT     = 31;
  localparam int          EXT_HI       = 14;
  localparam int          EXT_LO       = 11;
  localparam int          EVT_HI       = 10;
  localparam int          EVT_LO       = 5;
  localparam int          IRQ_BIT      = 4;
  localparam int          USER_BIT     = 3;
  localparam int          KERN_BIT     = 1;
  localparam int          EXC_BIT      = 0;
  localparam int          CNT_MSB      = 31;
  localparam int          NUM_EVENTS   = 64;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [31:0] ONE_WORD     = 32'h0000_0001;
  // Event codes, both counters
  localparam logic [5:0]  EV_CYCLES    = 6'h00;
  localparam logic [5:0]  EV_INSTR     = 6'h01;
  // Event codes, counter 0
  localparam logic [5:0]  EV0_BRANCH   = 6'h02;
  localparam logic [5:0]  EV0_RETURN   = 6'h03;
  localparam logic [5:0]  EV0_REGJUMP  = 6'h04;
  localparam logic [5:0]  EV0_INTEGER  = 6'h0E;
  localparam logic [5:0]  EV0_LOAD     = 6'h0F;
  localparam logic [5:0]  EV0_DIRJUMP  = 6'h10;
  localparam logic [5:0]  EV0_NOP      = 6'h11;
  localparam logic [5:0]  EV0_STALL    = 6'h12;
  localparam logic [5:0]  EV0_CSTORE   = 6'h13;
  localparam logic [5:0]  EV0_PREFETCH = 6'h14;
  localparam logic [5:0]  EV0_EXCEPT   = 6'h17;
  localparam logic [5:0]  EV0_CUSTOM   = 6'h1E;
  // Event codes, counter 1
  localparam logic [5:0]  EV1_STORE    = 6'h0F;
  localparam logic [5:0]  EV1_COMPACT  = 6'h10;
  localparam logic [5:0]  EV1_MULDIV   = 6'h11;
  localparam logic [5:0]  EV1_CSFAIL   = 6'h13;
  localparam logic [5:0]  EV1_ALUSTALL = 6'h19;
  localparam logic [5:0]  EV1_COP2EVT  = 6'h1C;
  localparam logic [5:0]  EV1_COP2MOVE = 6'h23;
  // Host controller register byte addresses
  localparam logic [7:0]  H_DATA       = 8'h00;
  localparam logic [7:0]  H_CMD        = 8'h04;
  localparam logic [7:0]  H_RESULT     = 8'h08;
  localparam logic [7:0]  H_MODE       = 8'h0C;
  localparam logic [7:0]  H_STATUS     = 8'h10;
  // Host command and mode fields
  localparam int          CMD_SEL_LO   = 0;
  localparam int          CMD_NUM_LO   = 4;
  localparam int          CMD_WR_BIT   = 16;
  localparam int          MODE_USER    = 0;
  localparam int          MODE_EXC     = 1;
  localparam int          MODE_ERR     = 2;
  localparam int          MODE_DEBUG   = 3;
  localparam int          MODE_SLEEP   = 4;
  localparam int          ST_IRQ       = 0;
  localparam int          ST_BUSY      = 1;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY   = 2'h0;
endpackage

// ==== tb/pec_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pec_checker_sva (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Register moves
  input  wire logic [4:0]  reg_num,
  input  wire logic [2:0]  sel,
  input  wire logic        move_to_sysctl,
  input  wire logic        move_from_sysctl,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] rdata,
  // Events and interrupt
  input  wire logic [63:0] ev0,
  input  wire logic        counter_irq
);
  logic        hit;
  logic        wr_cnt0;
  logic        rd_any;
  logic        clean0;
  logic [31:0] cnt0_shadow;
  logic [10:0] ctl0_shadow;
  logic        ie0;
  logic        ie1;

  assign hit     = (reg_num == pec_pkg::REG_NUM);
  assign wr_cnt0 = move_to_sysctl && hit && (sel == pec_pkg::SEL_CNT0);
  assign rd_any  = move_from_sysctl && hit;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Count 0 clean since its last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clean0      <= 1'b0;
      cnt0_shadow <= 32'h0000_0000;
    end else if (wr_cnt0) begin
      clean0      <= 1'b1;
      cnt0_shadow <= wdata;
    end else if (ev0 != 64'h0) begin
      clean0      <= 1'b0;
    end
  end

  // Last written control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_shadow <= 11'h000;
      ie0         <= 1'b0;
      ie1         <= 1'b0;
    end else if (move_to_sysctl && hit) begin
      if (sel == pec_pkg::SEL_CTL0) begin
        ctl0_shadow <= wdata[10:0];
        ie0         <= wdata[4];
      end
      if (sel == pec_pkg::SEL_CTL1) begin
        ie1 <= wdata[4];
      end
    end
  end

  property p_rd_other;
    move_from_sysctl && !hit |=> rdata == 32'h0000_0000;
  endproperty
  property p_rd_sel_hi;
    rd_any && sel > pec_pkg::SEL_CNT1 |=> rdata == 32'h0000_0000;
  endproperty
  property p_ctl_zero;
    rd_any && !sel[0] && !sel[2] |=> rdata[30:12] == 19'h0 && !rdata[2];
  endproperty
  property p_ctl0_more;
    rd_any && sel == pec_pkg::SEL_CTL0 |=> rdata[31];
  endproperty
  property p_cnt_readback;
    rd_any && sel == pec_pkg::SEL_CNT0 && clean0 |=> rdata == cnt0_shadow;
  endproperty
  property p_ctl_readback;
    rd_any && sel == pec_pkg::SEL_CTL0
      |=> rdata[10:0] == (ctl0_shadow & 11'h7FB);
  endproperty
  property p_irq_masked;
    !ie0 && !ie1 |-> !counter_irq;
  endproperty
  property p_irq_sw_clear;
    wr_cnt0 && !wdata[31] && !ie1 |=> !counter_irq;
  endproperty
  property p_irq_set;
    wr_cnt0 && wdata[31] && ie0 |=> counter_irq [*2];
  endproperty

  a_rd_other: assert property (p_rd_other)
    else $error("foreign register read not zero");
  a_rd_sel_hi: assert property (p_rd_sel_hi)
    else $error("unused select read not zero");
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("control zero bits not zero");
  a_ctl0_more: assert property (p_ctl0_more)
    else $error("control 0 top bit not set");
  a_cnt_readback: assert property (p_cnt_readback)
    else $error("count 0 differs from written value");
  a_ctl_readback: assert property (p_ctl_readback)
    else $error("control 0 fields differ from written value");
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with both enables low");
  a_irq_sw_clear: assert property (p_irq_sw_clear)
    else $error("interrupt not cleared by count write");
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt not raised by count write");

  c_cnt0_write: cover property (wr_cnt0);
  c_irq_rise: cover property ($rose(counter_irq));
  c_ctl1_read: cover property (rd_any && sel == pec_pkg::SEL_CTL1);
endmodule
`default_nettype wire

// ==== tb/tb_perf_event_counters.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_perf_event_counters;
  typedef struct packed {
    logic       c;
    logic [5:0] evt;
    logic [4:0] en;
    logic [4:0] mode;
    logic [5:0] pc;
    logic [1:0] exp;
  } pec_case_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [63:0] ev0_in;
  logic [63:0] ev1_in;
  logic        irq_out;
  logic [1:0]  counting;
  logic [31:0] r;
  int          n_errors;
  int          samples_checked;
  int          cycles;
  logic [5:0]  codes0 [14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h0E,
    6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h17, 6'h1E};
  logic [5:0]  codes1 [9] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h11, 6'h13,
    6'h19, 6'h1C, 6'h23};
  // Unit, event, enables, mode, pulse, count
  pec_case_t   cases [12] = '{
    {1'b0, 6'h01, 5'h02, 5'h00, 6'h01, 2'h3},
    {1'b0, 6'h01, 5'h02, 5'h01, 6'h01, 2'h0},
    {1'b0, 6'h01, 5'h08, 5'h01, 6'h01, 2'h3},
    {1'b0, 6'h01, 5'h08, 5'h00, 6'h01, 2'h0},
    {1'b0, 6'h01, 5'h01, 5'h02, 6'h01, 2'h3},
    {1'b0, 6'h01, 5'h02, 5'h02, 6'h01, 2'h0},
    {1'b0, 6'h01, 5'h01, 5'h06, 6'h01, 2'h0},
    {1'b0, 6'h00, 5'h0B, 5'h04, 6'h00, 2'h0},
    {1'b0, 6'h00, 5'h00, 5'h08, 6'h00, 2'h0},
    {1'b0, 6'h00, 5'h00, 5'h10, 6'h00, 2'h0},
    {1'b0, 6'h12, 5'h00, 5'h01, 6'h12, 2'h3},
    {1'b1, 6'h0F, 5'h02, 5'h00, 6'h01, 2'h0}};

  pec_if link_if ();
  pec_host pec_host_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .ev0_in    (ev0_in),
    .ev1_in    (ev1_in),
    .irq_out   (irq_out),
    .link      (link_if.host)
  );

  pec_counters pec_counters_i (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .link     (link_if.device),
    .counting (counting)
  );

  pec_checker_sva pec_checker_sva_i (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .reg_num          (link_if.reg_num),
    .sel              (link_if.sel),
    .move_to_sysctl   (link_if.move_to_sysctl),
    .move_from_sysctl (link_if.move_from_sysctl),
    .wdata            (link_if.wdata),
    .rdata            (link_if.rdata),
    .ev0              (link_if.ev0),
    .counter_irq      (link_if.counter_irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("checks made %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One AHB word transfer
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= pec_pkg::HTRANS_NSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask

  // Register move via the host
  task automatic mv(input logic w, input logic [4:0] num, input logic [2:0] s,
                    input logic [31:0] d, output logic [31:0] res);
    logic [31:0] st;
    if (w) wr(pec_pkg::H_DATA, d);
    wr(pec_pkg::H_CMD, {15'h0000, w, 7'h00, num, 1'b0, s});
    repeat (3) @(posedge hclk);
    st = 32'h0000_0002;
    while (st[pec_pkg::ST_BUSY] !== 1'b0) rd_reg(pec_pkg::H_STATUS, st);
    rd_reg(pec_pkg::H_RESULT, res);
  endtask

  task automatic mvw(input logic [2:0] s, input logic [31:0] d);
    mv(1'b1, pec_pkg::REG_NUM, s, d, r);
  endtask

  task automatic mvr(input logic [2:0] s, output logic [31:0] d);
    mv(1'b0, pec_pkg::REG_NUM, s, 32'h0000_0000, d);
  endtask

  task automatic pulse(input logic c, input logic [5:0] code, input int n);
    repeat (n) begin
      if (c) ev1_in <= 64'h1 << code;
      else ev0_in <= 64'h1 << code;
      @(posedge hclk);
    end
    ev0_in <= 64'h0;
    ev1_in <= 64'h0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic run_case(input pec_case_t k);
    wr(pec_pkg::H_MODE, {27'h0000000, k.mode});
    mvw({1'b0, k.c, 1'b0}, {21'h000000, k.evt, k.en});
    mvw({1'b0, k.c, 1'b1}, 32'h0000_0000);
    pulse(k.c, k.pc, 3);
    mvr({1'b0, k.c, 1'b1}, r);
    chk("event count", r, {30'h0, k.exp});
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ev0_in = 64'h0;
    ev1_in = 64'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    mvr(pec_pkg::SEL_CTL0, r);
    chk("ctl0 reset", r, 32'h8000_0000);
    mvr(pec_pkg::SEL_CTL1, r);
    chk("ctl1 reset", r, 32'h0000_0000);
    pulse(1'b0, pec_pkg::EV_CYCLES, 4);
    mvr(pec_pkg::SEL_CNT0, r);
    chk("idle count", r, 32'h0000_0000);
    chk("gate idle", {30'h0, counting}, 32'h0);
    chk("resp okay", {30'h0, hresp}, 32'h0);
    mv(1'b0, 5'h18, pec_pkg::SEL_CTL0, 32'h0000_0000, r);
    chk("foreign reg", r, 32'h0000_0000);
    mvr(3'h5, r);
    chk("unused sel", r, 32'h0000_0000);
    $display("test reset done");
    mvw(pec_pkg::SEL_CTL0, 32'h0000_0BDB);
    mvr(pec_pkg::SEL_CTL0, r);
    chk("ctl0 fields", r, 32'h8000_03DB);
    mvw(pec_pkg::SEL_CTL1, 32'h0000_0C7B);
    mvr(pec_pkg::SEL_CTL1, r);
    chk("ctl1 fields", r, 32'h0000_047B);
    mvw(pec_pkg::SEL_CNT1, 32'h5A5A_A5A5);
    mvr(pec_pkg::SEL_CNT1, r);
    chk("cnt1 value", r, 32'h5A5A_A5A5);
    chk("gate armed", {30'h0, counting}, 32'h3);
    $display("test fields done");
    foreach (codes0[i]) run_case({1'b0, codes0[i], 5'h02, 5'h00, codes0[i],
                                  2'h3});
    foreach (codes1[i]) run_case({1'b1, codes1[i], 5'h02, 5'h00, codes1[i],
                                  2'h3});
    $display("test event codes done");
    foreach (cases[i]) run_case(cases[i]);
    $display("test mode gating done");
    wr(pec_pkg::H_MODE, 32'h0000_0000);
    mvw(pec_pkg::SEL_CTL1, 32'h0000_0000);
    mvw(pec_pkg::SEL_CTL0, 32'h0000_0010);
    mvw(pec_pkg::SEL_CNT0, 32'h7FFF_FFFF);
    mvr(pec_pkg::SEL_CNT0, r);
    chk("count write", r, 32'h7FFF_FFFF);
    chk("irq before", {31'h0, irq_out}, 32'h0000_0000);
    pulse(1'b0, pec_pkg::EV_CYCLES, 1);
    chk("irq on top bit", {31'h0, irq_out}, 32'h0000_0001);
    pulse(1'b0, pec_pkg::EV_CYCLES, 2);
    mvr(pec_pkg::SEL_CNT0, r);
    chk("count under irq", r, 32'h8000_0002);
    rd_reg(pec_pkg::H_STATUS, r);
    chk("status irq", {31'h0, r[pec_pkg::ST_IRQ]}, 32'h0000_0001);
    mvw(pec_pkg::SEL_CNT0, 32'hFFFF_FFFF);
    pulse(1'b0, pec_pkg::EV_CYCLES, 1);
    mvr(pec_pkg::SEL_CNT0, r);
    chk("wrap", r, 32'h0000_0000);
    chk("irq after wrap", {31'h0, irq_out}, 32'h0000_0000);
    mvw(pec_pkg::SEL_CNT0, 32'h8000_0000);
    mvw(pec_pkg::SEL_CNT0, 32'h0000_0001);
    chk("irq sw clear", {31'h0, irq_out}, 32'h0000_0000);
    mvw(pec_pkg::SEL_CTL0, 32'h0000_0000);
    mvw(pec_pkg::SEL_CNT0, 32'h8000_0000);
    chk("irq masked", {31'h0, irq_out}, 32'h0000_0000);
    mvw(pec_pkg::SEL_CTL1, 32'h0000_0010);
    mvw(pec_pkg::SEL_CNT1, 32'h8000_0000);
    chk("irq counter 1", {31'h0, irq_out}, 32'h0000_0001);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
`default_nettype wire
